//--- core/isw_top.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
// Summary of operation
// - edge interrupt on rising edge if polarity bit set, else falling edge
// - a valid edge sets the edge flag, bit 1 of irq control
// - edge interrupt is suppressed while its enable, bit 4, is clear
// - edge interrupt wakes from sleep if enabled; global enable picks vector
// - timer rollover from maximum to zero sets timer flag, bit 2
// - timer flag interrupts only while timer enable, bit 5, is set
// - any level change on upper four port pins sets port flag, bit 0
// - port-change interrupt is gated by its own enable bit
// - port pins are compared every cycle, so a change coinciding with a port read is not missed
// - taking an interrupt pushes only the return address
// - watchdog runs from its own oscillator, also during sleep
// - watchdog time-out resets when awake, only wakes when asleep
// - watchdog stays disabled when its configuration fuse is clear
// - nominal 18 ms time-out, prescaler up to 1:128 lengthens it
// - clear instruction and sleep clear watchdog counter and prescaler
// - watchdog time-out clears the time-out status bit
// - sleep clears watchdog, clears power-down, sets time-out, stops oscillator
// - port pins hold their pre-sleep drive state during sleep
// - reset pin in sleep is full reset; other wake-ups continue
// - enabled interrupt wakes regardless of global enable; next instruction runs
// - enabled pending flag at sleep gives immediate wake after sleep
// - every wake-up from sleep clears the watchdog
// - global enable bit 7 passes or blocks all; reset clears it
// - response clears global enable, pushes return address, loads vector
module isw_top #(
    parameter int RC_TICK_NS = isw_pkg::RC_TICK_NS_DEF,
    parameter int WDT_BASE_TICKS = isw_pkg::WDT_TIMEOUT_NS / RC_TICK_NS,
    parameter int CNT_W = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [isw_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [isw_pkg::DATA_W-1:0] avs_writedata,
    output logic [isw_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire isw_pkg::isw_core_req_s core_req,
    input wire logic [isw_pkg::PC_W-1:0] core_pc,
    input wire logic timer_rollover,
    input wire logic edge_irq_pin,
    input wire logic [isw_pkg::UPPER_W-1:0] upper_port_pins,
    input wire logic watchdog_fuse_enable,
    input wire logic wdt_rc_osc,
    input wire logic [isw_pkg::PORT_W-1:0] core_port_out,
    input wire logic [isw_pkg::PORT_W-1:0] core_port_oe,
    output isw_pkg::isw_vec_s vec_out,
    output logic [isw_pkg::PORT_W-1:0] port_pin_out,
    output logic [isw_pkg::PORT_W-1:0] port_pin_oe,
    output logic sleeping,
    output logic osc_stop,
    output logic wake_pulse,
    output logic wdt_reset_pulse
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // hardware set wins over a software clear
    function automatic logic flag_next(input logic old, input logic set,
            input logic we, input logic wbit);
        logic n;
        n = old;
        if (we) begin
            n = wbit;
        end
        if (set) begin
            n = 1'b1;
        end
        return n;
    endfunction

    function automatic logic [isw_pkg::PRE_W-1:0] pre_mask(
            input logic [isw_pkg::PS_W-1:0] ps);
        logic [isw_pkg::PRE_W:0] one;
        one = {{isw_pkg::PRE_W{1'b0}}, 1'b1};
        return isw_pkg::PRE_W'((one << ps) - 1'b1);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] irq_ctrl_q;
    logic [7:0] option_q;
    logic to_q;
    logic pd_q;
    logic fuse_q;
    logic fuse_caught_q;
    logic sleeping_q;
    logic osc_stop_q;
    logic wake_q;
    logic wdt_reset_q;
    logic [CNT_W-1:0] wdt_cnt_q;
    logic [isw_pkg::PRE_W-1:0] wdt_pre_q;
    logic rc_s1_q, rc_s2_q, rc_prev_q;
    logic edge_s1_q, edge_s2_q, edge_prev_q;
    logic [isw_pkg::UPPER_W-1:0] port_s1_q, port_s2_q, port_prev_q;
    logic [isw_pkg::PORT_W-1:0] port_out_q, port_oe_q;
    isw_pkg::isw_vec_s vec_q;
    logic waitrequest_q;
    logic [isw_pkg::DATA_W-1:0] readdata_q;

    logic [7:0] idx;
    logic bus_req, bus_go, wr_ctrl, wr_opt;
    logic edge_ev, port_ev, rc_tick, pre_carry;
    logic irq_pend, take, sleep_entry, wake_ev, wdt_to, wdt_clr, wdt_run;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    assign idx = avs_address[isw_pkg::ADDR_W-1:isw_pkg::IDX_LSB];
    assign bus_req = avs_read | avs_write;
    // request is taken on the edge where waitrequest is seen low
    assign bus_go = bus_req & ~waitrequest_q;
    assign wr_ctrl = bus_go & avs_write & (idx == isw_pkg::IDX_IRQ_CTRL);
    assign wr_opt = bus_go & avs_write & (idx == isw_pkg::IDX_OPTION);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest_q <= 1'b1;
        end else begin
            waitrequest_q <= ~(bus_req & waitrequest_q);
        end
    end

    // unmapped reads return zero, unmapped writes are dropped
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata_q <= '0;
        end else if (avs_read & waitrequest_q) begin
            case (idx)
                isw_pkg::IDX_IRQ_CTRL: readdata_q <= 32'(irq_ctrl_q);
                isw_pkg::IDX_OPTION: readdata_q <= 32'(option_q);
                isw_pkg::IDX_STATUS: begin
                    readdata_q <= '0;
                    readdata_q[isw_pkg::B_TO] <= to_q;
                    readdata_q[isw_pkg::B_PD] <= pd_q;
                end
                default: readdata_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            edge_s1_q <= 1'b0;
            edge_s2_q <= 1'b0;
            edge_prev_q <= 1'b0;
            port_s1_q <= '0;
            port_s2_q <= '0;
            port_prev_q <= '0;
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            edge_s1_q <= edge_irq_pin;
            edge_s2_q <= edge_s1_q;
            edge_prev_q <= edge_s2_q;
            port_s1_q <= upper_port_pins;
            port_s2_q <= port_s1_q;
            port_prev_q <= port_s2_q;
            rc_s1_q <= wdt_rc_osc;
            rc_s2_q <= rc_s1_q;
            rc_prev_q <= rc_s2_q;
        end
    end

    assign edge_ev = (edge_s2_q != edge_prev_q)
        & (edge_s2_q == option_q[isw_pkg::B_EDGE]);
    // every cycle compared, so no change is lost to a port read
    assign port_ev = |(port_s2_q ^ port_prev_q);
    assign rc_tick = rc_s2_q & ~rc_prev_q;

    // ------------------------------------------------------------
    // interrupt control
    // ------------------------------------------------------------
    assign irq_pend =
        (irq_ctrl_q[isw_pkg::B_EIF] & irq_ctrl_q[isw_pkg::B_EIE])
        | (irq_ctrl_q[isw_pkg::B_TIF] & irq_ctrl_q[isw_pkg::B_TIE])
        | (irq_ctrl_q[isw_pkg::B_PCF] & irq_ctrl_q[isw_pkg::B_PCE]);
    // responses only at an instruction boundary while awake
    assign take = irq_pend & irq_ctrl_q[isw_pkg::B_GIE]
        & core_req.instr_done & ~sleeping_q & ~sleep_entry;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_ctrl_q <= isw_pkg::IRQ_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                irq_ctrl_q[7:3] <= avs_writedata[7:3];
            end
            if (take) begin
                irq_ctrl_q[isw_pkg::B_GIE] <= 1'b0;
            end
            irq_ctrl_q[isw_pkg::B_EIF] <= flag_next(
                irq_ctrl_q[isw_pkg::B_EIF], edge_ev, wr_ctrl,
                avs_writedata[isw_pkg::B_EIF]);
            irq_ctrl_q[isw_pkg::B_TIF] <= flag_next(
                irq_ctrl_q[isw_pkg::B_TIF], timer_rollover, wr_ctrl,
                avs_writedata[isw_pkg::B_TIF]);
            irq_ctrl_q[isw_pkg::B_PCF] <= flag_next(
                irq_ctrl_q[isw_pkg::B_PCF], port_ev, wr_ctrl,
                avs_writedata[isw_pkg::B_PCF]);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            option_q <= isw_pkg::OPTION_RST;
        end else if (wr_opt) begin
            option_q <= avs_writedata[7:0];
        end
    end

    // only the return address goes out; no other context is saved
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            vec_q <= '0;
        end else begin
            vec_q.push <= take;
            vec_q.load <= take;
            vec_q.vector <= isw_pkg::IRQ_VECTOR;
            if (take) begin
                vec_q.ret_pc <= core_pc;
            end
        end
    end

    // ------------------------------------------------------------
    // sleep and wake
    // ------------------------------------------------------------
    assign sleep_entry = core_req.sleep_exec & ~sleeping_q;
    // a flag already pending wakes on the cycle after entry
    assign wake_ev = sleeping_q & (irq_pend | wdt_to);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sleeping_q <= 1'b0;
            osc_stop_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_ev;
            if (sleep_entry) begin
                sleeping_q <= 1'b1;
                osc_stop_q <= 1'b1;
            end else if (wake_ev) begin
                sleeping_q <= 1'b0;
                osc_stop_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            port_out_q <= '0;
            port_oe_q <= '0;
        end else if (!sleeping_q) begin
            port_out_q <= core_port_out;
            port_oe_q <= core_port_oe;
        end // held while asleep
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    // fuse is a strap: caught once, on the first edge after release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fuse_q <= 1'b0;
            fuse_caught_q <= 1'b0;
        end else if (!fuse_caught_q) begin
            fuse_q <= watchdog_fuse_enable;
            fuse_caught_q <= 1'b1;
        end
    end

    assign wdt_run = fuse_q;
    assign wdt_clr = core_req.wdt_clear | sleep_entry | wake_ev;
    assign pre_carry = ~option_q[isw_pkg::B_PSA]
        | (wdt_pre_q >= pre_mask(option_q[isw_pkg::PS_LSB+:isw_pkg::PS_W]));
    // not via wdt_clr: it loops back through wake_ev
    assign wdt_to = wdt_run & rc_tick & pre_carry
        & ~core_req.wdt_clear & ~sleep_entry
        & (wdt_cnt_q == CNT_W'(WDT_BASE_TICKS - 1));

    // prescaler only divides when assigned to the watchdog
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_pre_q <= '0;
        end else if (wdt_clr || !wdt_run || !option_q[isw_pkg::B_PSA]) begin
            wdt_pre_q <= '0;
        end else if (rc_tick) begin
            wdt_pre_q <= pre_carry ? '0 : wdt_pre_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_cnt_q <= '0;
        end else if (wdt_clr || !wdt_run || wdt_to) begin
            wdt_cnt_q <= '0;
        end else if (rc_tick && pre_carry) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reset_q <= 1'b0;
        end else begin
            wdt_reset_q <= wdt_to & ~sleeping_q;
        end
    end

    // power-up leaves both status bits set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (wdt_to) begin
            to_q <= 1'b0;
        end else if (sleep_entry) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end else if (core_req.wdt_clear) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = readdata_q;
    assign avs_waitrequest = waitrequest_q;
    assign vec_out = vec_q;
    assign port_pin_out = port_out_q;
    assign port_pin_oe = port_oe_q;
    assign sleeping = sleeping_q;
    assign osc_stop = osc_stop_q;
    assign wake_pulse = wake_q;
    assign wdt_reset_pulse = wdt_reset_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_edge_polarity: assert property (
        edge_s2_q != edge_prev_q && !wr_ctrl
            && edge_s2_q != option_q[isw_pkg::B_EDGE]
            && !irq_ctrl_q[isw_pkg::B_EIF] |=> !irq_ctrl_q[isw_pkg::B_EIF])
        else $error("edge flag raised on wrong polarity");
    a_edge_flag_set: assert property (
        edge_ev |=> irq_ctrl_q[isw_pkg::B_EIF])
        else $error("edge flag not set by valid edge");
    a_timer_flag_set: assert property (
        timer_rollover |=> irq_ctrl_q[isw_pkg::B_TIF])
        else $error("timer flag not set on rollover");
    a_port_flag_set: assert property (
        port_s2_q != port_prev_q |=> irq_ctrl_q[isw_pkg::B_PCF])
        else $error("port flag not set on change");
    a_vector_load: assert property (
        take |=> vec_q.load && vec_q.push
            && vec_q.vector == isw_pkg::IRQ_VECTOR
            && !irq_ctrl_q[isw_pkg::B_GIE])
        else $error("interrupt response incomplete");
    a_gie_blocks: assert property (
        vec_q.load |-> $past(irq_ctrl_q[isw_pkg::B_GIE]))
        else $error("vector taken with global enable clear");
    a_sleep_entry: assert property (
        sleep_entry |=> sleeping_q && !pd_q && to_q && osc_stop_q
            && wdt_cnt_q == '0)
        else $error("sleep entry state wrong");
    a_wdt_reset_awake: assert property (
        wdt_to && !sleeping_q |=> wdt_reset_q && !to_q && !wake_q)
        else $error("awake time-out did not reset");
    a_port_hold: assert property (
        sleeping_q && $past(sleeping_q) |-> $stable(port_out_q)
            && $stable(port_oe_q))
        else $error("port drive changed during sleep");
    a_fuse_off: assert property (
        fuse_caught_q && !fuse_q |-> wdt_cnt_q == '0 && !wdt_reset_q)
        else $error("watchdog ran with fuse clear");
    a_irq_wake: assert property (
        sleeping_q && irq_pend |=> wake_q && !sleeping_q)
        else $error("enabled interrupt did not wake");
    a_bus_answer: assert property (
        bus_req && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q)
        else $error("bus answer not in one wait cycle");

endmodule // isw_top

//--- core/isw_pkg.sv
package isw_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h03;
    localparam logic [7:0] IDX_IRQ_CTRL = 8'h0B;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;

    // irq_control_reg fields
    localparam int B_GIE = 7;
    localparam int B_TIE = 5;
    localparam int B_EIE = 4;
    localparam int B_PCE = 3;
    localparam int B_TIF = 2;
    localparam int B_EIF = 1;
    localparam int B_PCF = 0;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;

    // timer_prescale_config fields
    localparam int B_EDGE = 6;
    localparam int B_PSA = 3;
    localparam int PS_LSB = 0;
    localparam int PS_W = 3;
    localparam logic [7:0] OPTION_RST = 8'hFF;

    // status fields
    localparam int B_TO = 4;
    localparam int B_PD = 3;

    localparam int PC_W = 13;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam int PRE_W = 7;
    localparam int PORT_W = 8;
    localparam int UPPER_W = 4;

    // watchdog period without prescaler
    localparam int WDT_TIMEOUT_NS = 18000000;
    localparam int RC_TICK_NS_DEF = 1000;

    typedef struct packed {
        logic sleep_exec;
        logic wdt_clear;
        logic instr_done;
    } isw_core_req_s;

    typedef struct packed {
        logic push;
        logic load;
        logic [12:0] ret_pc;
        logic [12:0] vector;
    } isw_vec_s;
endpackage

//--- tb/isw_core_model.sv
`timescale 1ns/1ns
// core side: one instruction per cycle while awake, stack of depth one
module isw_core_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sleeping,
    input wire isw_pkg::isw_vec_s vec_out,
    input wire logic do_sleep,
    input wire logic do_clear,
    input wire logic keep_alive,
    output isw_pkg::isw_core_req_s core_req,
    output logic [isw_pkg::PC_W-1:0] core_pc,
    output logic [7:0] push_cnt
);
    logic [3:0] alive_q;
    logic [isw_pkg::PC_W-1:0] stack_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_req <= '0;
            core_pc <= '0;
            push_cnt <= 8'h00;
            alive_q <= 4'h0;
            stack_q <= '0;
        end else begin
            // core is stopped while asleep, so no boundary then
            core_req.instr_done <= ~sleeping & ~do_sleep;
            core_req.sleep_exec <= do_sleep & ~sleeping;
            // periodic clear keeps the watchdog quiet between tests
            core_req.wdt_clear <= ~sleeping
                & (do_clear | (keep_alive & (alive_q == 4'h0)));
            alive_q <= alive_q + 4'h1;
            if (vec_out.load) begin
                core_pc <= vec_out.vector;
            end else if (core_req.instr_done) begin
                core_pc <= core_pc + 13'h0001;
            end
            if (vec_out.push) begin
                stack_q <= vec_out.ret_pc;
                push_cnt <= push_cnt + 8'h01;
            end
        end
    end
endmodule // isw_core_model

//--- tb/isw_top_tb.sv
`timescale 1ns/1ns
module isw_top_tb;
    logic clock, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [isw_pkg::ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    isw_pkg::isw_core_req_s core_req;
    logic [isw_pkg::PC_W-1:0] core_pc, prev_pc;
    logic timer_rollover, edge_irq_pin, fuse, rc_osc, sleeping, osc_stop;
    logic [3:0] upper_port_pins;
    logic [7:0] port_out, port_oe, pin_out, pin_oe, push_cnt;
    logic wake_pulse, wdt_reset_pulse, do_sleep, do_clear, keep_alive;
    isw_pkg::isw_vec_s vec_out;
    int err_total, n_tests, wake_cnt, rst_cnt, n, w0, p0, r0;

    isw_top #(.WDT_BASE_TICKS(4)) i_dut (
        .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_req(core_req),
        .core_pc(core_pc), .timer_rollover(timer_rollover),
        .edge_irq_pin(edge_irq_pin), .upper_port_pins(upper_port_pins),
        .watchdog_fuse_enable(fuse), .wdt_rc_osc(rc_osc),
        .core_port_out(port_out), .core_port_oe(port_oe),
        .vec_out(vec_out), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .sleeping(sleeping), .osc_stop(osc_stop), .wake_pulse(wake_pulse),
        .wdt_reset_pulse(wdt_reset_pulse));

    isw_core_model i_core (
        .clock(clock), .reset_n(reset_n), .sleeping(sleeping),
        .vec_out(vec_out), .do_sleep(do_sleep), .do_clear(do_clear),
        .keep_alive(keep_alive), .core_req(core_req), .core_pc(core_pc),
        .push_cnt(push_cnt));

    // ----------------------------------------
    // clocks, closing and monitors
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // free-running watchdog oscillator, 9 system cycles a period
    initial begin
        rc_osc = 1'b0;
        forever #36 rc_osc = ~rc_osc;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
        end
    endtask

    always @(posedge clock) begin
        prev_pc <= core_pc;
        if (wake_pulse === 1'b1) wake_cnt <= wake_cnt + 1;
        if (wdt_reset_pulse === 1'b1) rst_cnt <= rst_cnt + 1;
        if (vec_out.push === 1'b1) begin
            chk("ret_pc", 32'(prev_pc), 32'(vec_out.ret_pc));
            chk("vector", 32'h4, 32'(vec_out.vector));
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("CHECK FAILED run time limit reached");
        summarize();
    end

    // ----------------------------------------
    // bus and stimulus tasks
    // ----------------------------------------
    task automatic bus_go(input logic [7:0] idx, input logic rd,
                          input logic [31:0] wd, output logic [31:0] rdat);
        int k;
        k = 0;
        avs_address <= {idx, 2'b00};
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= wd;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk("wait cycles", 32'h2, 32'(k));
        @(posedge clock);
    endtask

    task automatic bus_rd(input logic [7:0] idx, output logic [31:0] v);
        bus_go(idx, 1'b1, 32'h0, v);
    endtask

    task automatic bus_wr(input logic [7:0] idx, input logic [31:0] v);
        logic [31:0] x;
        bus_go(idx, 1'b0, v, x);
    endtask

    // drive pins, read the flags back, then clear the control register
    task automatic pin_step(input logic e, input logic [3:0] p,
                            input logic [31:0] ex);
        logic [31:0] v;
        edge_irq_pin <= e;
        upper_port_pins <= p;
        repeat (6) @(posedge clock);
        bus_rd(isw_pkg::IDX_IRQ_CTRL, v);
        chk("irq_ctrl", ex, v);
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h0);
    endtask

    task automatic roll();
        timer_rollover <= 1'b1;
        @(posedge clock);
        timer_rollover <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic sleep_now();
        do_sleep <= 1'b1;
        @(posedge clock);
        do_sleep <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic wdt_time(output int c);
        int r;
        r = rst_cnt;
        c = 0;
        do_clear <= 1'b1;
        @(posedge clock);
        do_clear <= 1'b0;
        while (rst_cnt == r && c < 300) begin
            @(posedge clock);
            c++;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {err_total, n_tests, wake_cnt, rst_cnt} = '0;
        reset_n = 1'b0;
        {avs_read, avs_write, timer_rollover, edge_irq_pin} = '0;
        {avs_address, avs_writedata, upper_port_pins} = '0;
        {do_sleep, do_clear, port_out, port_oe} = '0;
        fuse = 1'b1;
        keep_alive = 1'b1;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        bus_rd(isw_pkg::IDX_IRQ_CTRL, d);
        chk("irq_ctrl reset", 32'h00, d);
        bus_rd(isw_pkg::IDX_OPTION, d);
        chk("option reset", 32'hFF, d);
        bus_rd(isw_pkg::IDX_STATUS, d);
        chk("status reset", 32'h18, d & 32'h18);
        bus_rd(8'h40, d);
        chk("unmapped", 32'h0, d);
        p0 = push_cnt;
        roll();
        bus_rd(isw_pkg::IDX_IRQ_CTRL, d);
        chk("timer flag", 32'h04, d);
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h0);
        pin_step(1'b1, 4'h0, 32'h02);
        pin_step(1'b0, 4'h0, 32'h00);
        bus_wr(isw_pkg::IDX_OPTION, 32'hBF);
        pin_step(1'b1, 4'h0, 32'h00);
        pin_step(1'b0, 4'h0, 32'h02);
        pin_step(1'b0, 4'h8, 32'h01);
        pin_step(1'b0, 4'h0, 32'h01);
        chk("no take gie off", 32'(p0), 32'(push_cnt));
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'hA0);
        roll();
        chk("timer take", 32'(p0 + 1), 32'(push_cnt));
        bus_rd(isw_pkg::IDX_IRQ_CTRL, d);
        chk("gie cleared", 32'h24, d);
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h80);
        roll();
        chk("timer masked", 32'(p0 + 1), 32'(push_cnt));
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h80);
        pin_step(1'b1, 4'h0, 32'h80);
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h80);
        pin_step(1'b0, 4'h0, 32'h82);
        chk("edge masked", 32'(p0 + 1), 32'(push_cnt));
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h88);
        pin_step(1'b0, 4'h8, 32'h09);
        chk("port take", 32'(p0 + 2), 32'(push_cnt));
        // sleep, frozen port drive, wake by edge with global enable off
        port_out <= 8'h5A;
        port_oe <= 8'hF0;
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h10);
        w0 = wake_cnt;
        sleep_now();
        chk("sleeping", 32'h1, 32'({sleeping, osc_stop} == 2'b11));
        bus_rd(isw_pkg::IDX_STATUS, d);
        chk("status sleep", 32'h10, d & 32'h18);
        port_out <= 8'hA5;
        port_oe <= 8'h0F;
        repeat (3) @(posedge clock);
        chk("pins held", 32'h5AF0, 32'({pin_out, pin_oe}));
        pin_step(1'b1, 4'h8, 32'h10);
        chk("still asleep", 32'h1, 32'(sleeping));
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h10);
        pin_step(1'b0, 4'h8, 32'h12);
        chk("edge wake", 32'(w0 + 1), 32'(wake_cnt));
        chk("no vector", 32'(p0 + 2), 32'(push_cnt));
        chk("pins follow", 32'hA5, 32'(pin_out));
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h08);
        upper_port_pins <= 4'h0;
        repeat (6) @(posedge clock);
        sleep_now();
        repeat (3) @(posedge clock);
        chk("pending wake", 32'(w0 + 2), 32'(wake_cnt));
        bus_wr(isw_pkg::IDX_IRQ_CTRL, 32'h0);
        // watchdog periods, measured in system cycles
        keep_alive <= 1'b0;
        bus_wr(isw_pkg::IDX_OPTION, 32'hB8);
        wdt_time(n);
        chk("wdt ps0", 32'h1, 32'(n >= 24 && n <= 48));
        bus_rd(isw_pkg::IDX_STATUS, d);
        chk("to cleared", 32'h0, d & 32'h10);
        bus_wr(isw_pkg::IDX_OPTION, 32'hB9);
        wdt_time(n);
        chk("wdt ps1", 32'h1, 32'(n >= 60 && n <= 84));
        bus_wr(isw_pkg::IDX_OPTION, 32'hB8);
        r0 = rst_cnt;
        w0 = wake_cnt;
        sleep_now();
        n = 0;
        while (wake_cnt == w0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        while (rst_cnt == r0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        chk("wdt wake", 32'(w0 + 1), 32'(wake_cnt));
        chk("wdt after wake", 32'h1, 32'(n >= 24 && n <= 48));
        bus_rd(isw_pkg::IDX_STATUS, d);
        chk("status wdt", 32'h0, d & 32'h18);
        keep_alive <= 1'b1;
        r0 = rst_cnt;
        repeat (200) @(posedge clock);
        chk("clear holds off", 32'(r0), 32'(rst_cnt));
        // master reset while asleep, fuse now off
        sleep_now();
        fuse <= 1'b0;
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk("reset wakes", 32'h0, 32'(sleeping));
        bus_rd(isw_pkg::IDX_STATUS, d);
        chk("status reset", 32'h18, d & 32'h18);
        keep_alive <= 1'b0;
        bus_wr(isw_pkg::IDX_OPTION, 32'hB8);
        r0 = rst_cnt;
        repeat (200) @(posedge clock);
        chk("fuse off", 32'(r0), 32'(rst_cnt));
        summarize();
    end
endmodule // isw_top_tb
